// >>> verilog/eis_irq_status.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "eis_cfg.svh"

module eis_irq_status (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // avalon-mm slave
   input wire logic [31:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // event sources
   input wire eis_pkg::eis_events_s events_i,
   input wire eis_pkg::eis_tx_frame_s tx_frame_i,
   // interrupt
   output logic irq_o
);

   eis_pkg::eis_word_t status;
   eis_pkg::eis_word_t mask;
   eis_pkg::eis_word_t next_mask;
   eis_pkg::eis_word_t tx64_count;
   eis_pkg::eis_word_t read_snapshot;
   eis_pkg::eis_word_t next_status;
   eis_pkg::eis_word_t set_vec;
   eis_pkg::eis_word_t clr_vec;
   eis_pkg::eis_word_t be_mask;
   logic rd_take;
   logic wr_take;
   logic good_64;

   function automatic eis_pkg::eis_word_t event_vector(input eis_pkg::eis_events_s ev);
      eis_pkg::eis_word_t v;
      v = 32'h0000_0000;
      v[`EIS_BIT_MGMT_DONE] = ev.mgmt_done;
      v[`EIS_BIT_RX_DONE] = ev.rx_done;
      v[`EIS_BIT_RX_DESC_OWNED] = ev.rx_desc_owned_read;
      v[`EIS_BIT_TX_DESC_OWNED] = ev.tx_desc_owned_read;
      v[`EIS_BIT_TX_UNDERRUN] = ev.tx_abort_no_data
         | ev.tx_status_wb_overlap
         | ev.tx_sop_bus_fault;
      v[`EIS_BIT_RETRY_LIMIT] = ev.retry_limit_hit;
      v[`EIS_BIT_TX_BUS_CORRUPT] = ev.tx_frame_bus_corrupt;
      v[`EIS_BIT_TX_DONE] = ev.tx_done;
      v[`EIS_BIT_RX_OVERRUN] = ev.rx_overrun;
      v[`EIS_BIT_HRESP] = ev.hresp_not_ok;
      return v;
   endfunction

   function automatic eis_pkg::eis_word_t lanes(input logic [3:0] be);
      eis_pkg::eis_word_t m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // a transfer completes at the edge where waitrequest is seen low
   assign rd_take = avs_read_i && !avs_waitrequest_o;
   assign wr_take = avs_write_i && !avs_waitrequest_o;
   assign be_mask = lanes(avs_byteenable_i);
   assign set_vec = event_vector(events_i);

   // one wait cycle: the snapshot is taken, then handed back
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         avs_waitrequest_o <= 1'b0;
      end
   end

   // readdata stays frozen while the master collects it
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         unique case (avs_address_i)
            `EIS_STATUS_ADDR: avs_readdata_o <= status & mask;
            `EIS_MASK_ADDR: avs_readdata_o <= mask;
            `EIS_TX64_COUNT_ADDR: avs_readdata_o <= tx64_count;
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      read_snapshot = avs_readdata_o;
   end

   // only what the master actually saw is cleared; w1c also honoured
   always_comb begin
      clr_vec = 32'h0000_0000;
      if (rd_take && avs_address_i == `EIS_STATUS_ADDR) begin
         clr_vec = read_snapshot;
      end else if (wr_take && avs_address_i == `EIS_STATUS_ADDR) begin
         clr_vec = avs_writedata_i & be_mask;
      end
   end

   // mask update seen by status in the same edge, so a cleared mask
   // bit never leaves a stale status bit or irq behind for one cycle
   always_comb begin
      next_mask = mask;
      if (wr_take && avs_address_i == `EIS_MASK_ADDR) begin
         next_mask = (mask & ~be_mask) | (avs_writedata_i & be_mask);
      end
   end

   // set wins over clear; masked sources never latch
   assign next_status = ((status & ~clr_vec) | set_vec) & next_mask;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         status <= `EIS_STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   // registered from the same next value so it tracks status exactly
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |next_status;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mask <= `EIS_MASK_RESET;
      end else begin
         mask <= next_mask;
      end
   end

   assign good_64 = events_i.tx_done && tx_frame_i.len == `EIS_FRAME_LEN_64
      && !tx_frame_i.is_pause
      && !tx_frame_i.had_underrun && !tx_frame_i.retry_exceeded;

   // wraps silently at full scale; no write path by design
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tx64_count <= `EIS_COUNT_RESET;
      end else if (good_64) begin
         tx64_count <= tx64_count + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   sequence status_read_done;
      rd_take && avs_address_i == `EIS_STATUS_ADDR;
   endsequence

   sequence status_write_done;
      wr_take && avs_address_i == `EIS_STATUS_ADDR;
   endsequence

   sequence mask_write_full;
      wr_take && avs_address_i == `EIS_MASK_ADDR && avs_byteenable_i == 4'hf;
   endsequence

   sequence read_issued;
      avs_read_i && avs_waitrequest_o;
   endsequence

   sequence no_events;
      set_vec == 32'h0000_0000;
   endsequence

   // nothing on the bus touches status or mask in this cycle
   sequence status_untouched;
      !(wr_take || rd_take) ||
         (avs_address_i != `EIS_STATUS_ADDR && avs_address_i != `EIS_MASK_ADDR);
   endsequence

   masked_reads_zero_a: assert property ((status & ~mask) == 32'h0000_0000)
      else $error("status bit set for a masked source");

   irq_tracks_status_a: assert property (irq_o == (status != 32'h0000_0000))
      else $error("interrupt out of step with status");

   mgmt_done_set_a: assert property (events_i.mgmt_done && mask[0] |=> status[0])
      else $error("management done not latched");

   rx_done_set_a: assert property (events_i.rx_done && mask[1] |=> status[1])
      else $error("receive complete not latched");

   rx_owned_set_a: assert property (events_i.rx_desc_owned_read && mask[2] |=> status[2])
      else $error("owned rx descriptor not latched");

   tx_owned_set_a: assert property (events_i.tx_desc_owned_read && mask[3] |=> status[3])
      else $error("owned tx descriptor not latched");

   abort_underrun_set_a: assert property (events_i.tx_abort_no_data && mask[4] |=> status[4])
      else $error("starvation underrun not latched");

   wb_underrun_set_a: assert property (events_i.tx_status_wb_overlap && mask[4] |=> status[4])
      else $error("writeback overlap underrun not latched");

   sop_underrun_set_a: assert property (events_i.tx_sop_bus_fault && mask[4] |=> status[4])
      else $error("post-sop fault underrun not latched");

   retry_set_a: assert property (events_i.retry_limit_hit && mask[5] |=> status[5])
      else $error("retry limit not latched");

   bus_corrupt_set_a: assert property (events_i.tx_frame_bus_corrupt && mask[6]
      |=> status[6])
      else $error("tx bus corruption not latched");

   tx_done_set_a: assert property (events_i.tx_done && mask[7] |=> status[7])
      else $error("transmit complete not latched");

   overrun_set_a: assert property (events_i.rx_overrun && mask[10] |=> status[10])
      else $error("receive overrun not latched");

   hresp_set_a: assert property (events_i.hresp_not_ok && mask[11] |=> status[11])
      else $error("bad bus response not latched");

   // an event with its mask bit low is dropped, not held for later
   masked_drop_a: assert property (status_untouched and (status == 32'h0000_0000)
      and (mask == 32'h0000_0000) |=> status == 32'h0000_0000)
      else $error("masked event latched");

   mask_clear_drops_a: assert property (mask_write_full
      |=> (status & ~$past(avs_writedata_i)) == 32'h0000_0000)
      else $error("status kept after mask bit cleared");

   mask_write_a: assert property (mask_write_full |=> mask == $past(avs_writedata_i))
      else $error("mask write lost");

   reserved_zero_a: assert property (status[31:12] == 20'h0_0000 && status[9:8] == 2'h0)
      else $error("reserved status bit set");

   read_clears_a: assert property (status_read_done and no_events
      |=> (status & $past(avs_readdata_o)) == 32'h0000_0000)
      else $error("read did not clear returned bits");

   read_keeps_new_a: assert property (status_read_done ##0 (set_vec[7] && mask[7])
      |=> status[7] [*1])
      else $error("event lost during clearing read");

   sticky_bits_a: assert property (status_untouched
      |=> (status & $past(status)) == $past(status))
      else $error("status bit dropped with no clear");

   w1c_clears_a: assert property (status_write_done and no_events
      and (avs_byteenable_i == 4'hf)
      |=> (status & $past(avs_writedata_i)) == 32'h0000_0000)
      else $error("write one did not clear status");

   read_wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");

   wait_idle_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
      |=> avs_waitrequest_o)
      else $error("waitrequest dropped with no request");

   // readdata must not move in the cycle the master takes it
   readdata_hold_a: assert property (!avs_waitrequest_o |=> $stable(avs_readdata_o))
      else $error("read data moved under the master");

   status_read_value_a: assert property (read_issued ##0 (avs_address_i == `EIS_STATUS_ADDR)
      |=> avs_readdata_o == $past(status))
      else $error("status read returned wrong value");

   count_read_value_a: assert property (read_issued
      ##0 (avs_address_i == `EIS_TX64_COUNT_ADDR)
      |=> avs_readdata_o == $past(tx64_count))
      else $error("count read returned wrong value");

   unmapped_read_a: assert property (read_issued ##0 (avs_address_i != `EIS_STATUS_ADDR
      && avs_address_i != `EIS_MASK_ADDR && avs_address_i != `EIS_TX64_COUNT_ADDR)
      |=> avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   count_good_a: assert property (good_64 |=> tx64_count == $past(tx64_count) + 32'h0000_0001)
      else $error("good 64-byte frame not counted");

   count_idle_a: assert property (!events_i.tx_done |=> $stable(tx64_count))
      else $error("count moved with no frame");

   count_len_a: assert property (events_i.tx_done && tx_frame_i.len != `EIS_FRAME_LEN_64
      |=> $stable(tx64_count))
      else $error("frame of other length counted");

   count_bad_a: assert property (events_i.tx_done && (tx_frame_i.had_underrun
      || tx_frame_i.retry_exceeded || tx_frame_i.is_pause) |=> $stable(tx64_count))
      else $error("bad frame counted");

endmodule

// >>> shared/eis_cfg.svh
`ifndef EIS_CFG_SVH
`define EIS_CFG_SVH

// register byte addresses
`define EIS_STATUS_ADDR 32'hf8008024
`define EIS_MASK_ADDR 32'hf8008028
`define EIS_TX64_COUNT_ADDR 32'hf8008118

// status bit positions
`define EIS_BIT_MGMT_DONE 0
`define EIS_BIT_RX_DONE 1
`define EIS_BIT_RX_DESC_OWNED 2
`define EIS_BIT_TX_DESC_OWNED 3
`define EIS_BIT_TX_UNDERRUN 4
`define EIS_BIT_RETRY_LIMIT 5
`define EIS_BIT_TX_BUS_CORRUPT 6
`define EIS_BIT_TX_DONE 7
`define EIS_BIT_RX_OVERRUN 10
`define EIS_BIT_HRESP 11

// reset values and frame size of interest
`define EIS_STATUS_RESET 32'h0000_0000
`define EIS_MASK_RESET 32'h0000_0000
`define EIS_COUNT_RESET 32'h0000_0000
`define EIS_FRAME_LEN_64 14'h0040

`endif

// >>> shared/eis_pkg.sv
package eis_pkg;

   // one-cycle event pulses from the mac and dma
   typedef struct packed {
      logic mgmt_done;
      logic rx_done;
      logic rx_desc_owned_read;
      logic tx_desc_owned_read;
      logic tx_abort_no_data;
      logic tx_status_wb_overlap;
      logic tx_sop_bus_fault;
      logic retry_limit_hit;
      logic tx_frame_bus_corrupt;
      logic tx_done;
      logic rx_overrun;
      logic hresp_not_ok;
   } eis_events_s;

   // description of the frame that ends with tx_done
   typedef struct packed {
      logic [13:0] len;
      logic is_pause;
      logic had_underrun;
      logic retry_exceeded;
   } eis_tx_frame_s;

   typedef logic [31:0] eis_word_t;

endpackage

// >>> sim/eis_event_src.sv
`timescale 1ns/1ps
// stands in for the mac and dma event sources
module eis_event_src (
   // clock
   input wire logic core_clk_i,
   // request from the bench
   input wire logic fire_i,
   input wire eis_pkg::eis_events_s ev_i,
   input wire eis_pkg::eis_tx_frame_s frame_i,
   // towards the block
   output eis_pkg::eis_events_s events_o,
   output eis_pkg::eis_tx_frame_s tx_frame_o
);
   // pulses last one cycle; frame lines toggle between frames, never hold
   always_ff @(posedge core_clk_i) begin
      events_o <= fire_i ? ev_i : '0;
      tx_frame_o <= fire_i ? frame_i : ~tx_frame_o;
   end
endmodule

// >>> sim/eis_irq_status_bench.sv
`timescale 1ns/1ps
`include "eis_cfg.svh"
module eis_irq_status_bench;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [31:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic wait_req;
   logic irq;
   logic fire = 1'b0;
   eis_pkg::eis_events_s ev_req = '0;
   eis_pkg::eis_tx_frame_s fr_req = '0;
   eis_pkg::eis_events_s events;
   eis_pkg::eis_tx_frame_s tx_frame;
   int n_errors = 0;
   int checks = 0;
   logic [31:0] got;
   // status bit reached by each event, indexed by struct bit
   int pos[12] = '{11, 10, 7, 6, 5, 4, 4, 4, 3, 2, 1, 0};
   // 64 good, pause, underrun, retry, 63, 65, 64 good
   logic [16:0] frames[7] = '{17'h00200, 17'h00204, 17'h00202, 17'h00201,
      17'h001f8, 17'h00208, 17'h00200};

   eis_irq_status dut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_req), .events_i(events), .tx_frame_i(tx_frame),
      .irq_o(irq));
   eis_event_src src (
      .core_clk_i(core_clk_i), .fire_i(fire), .ev_i(ev_req), .frame_i(fr_req),
      .events_o(events), .tx_frame_o(tx_frame));

   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end

   task automatic end_sim();
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // request held until the rising edge at which waitrequest is seen low
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_errors++;
         end_sim();
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(got, e);
   endtask

   task automatic irqchk(input logic e);
      @(negedge core_clk_i);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   task automatic pulse(input logic [11:0] e, input logic [16:0] f);
      @(posedge core_clk_i);
      ev_req <= e;
      fr_req <= f;
      fire <= 1'b1;
      @(posedge core_clk_i);
      fire <= 1'b0;
      repeat (2) @(posedge core_clk_i);
   endtask

   initial begin
      repeat (4) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rdchk(`EIS_STATUS_ADDR, `EIS_STATUS_RESET);
      rdchk(`EIS_MASK_ADDR, `EIS_MASK_RESET);
      rdchk(`EIS_TX64_COUNT_ADDR, `EIS_COUNT_RESET);
      rdchk(32'hf8008030, 32'h0);
      pulse(12'hfff, 17'h0);
      irqchk(1'b0);
      rdchk(`EIS_STATUS_ADDR, 32'h0);
      xfer(1'b1, `EIS_MASK_ADDR, 32'h0000_0cff);
      rdchk(`EIS_MASK_ADDR, 32'h0000_0cff);
      for (int i = 0; i < 12; i++) begin
         pulse(12'h001 << i, 17'h0);
         irqchk(1'b1);
         rdchk(`EIS_STATUS_ADDR, 32'h1 << pos[i]);
         rdchk(`EIS_STATUS_ADDR, 32'h0);
         irqchk(1'b0);
      end
      pulse(12'hc00, 17'h0);
      xfer(1'b1, `EIS_STATUS_ADDR, 32'h1);
      rdchk(`EIS_STATUS_ADDR, 32'h2);
      for (int i = 0; i < 7; i++) pulse(12'h004, frames[i]);
      rdchk(`EIS_TX64_COUNT_ADDR, 32'h2);
      xfer(1'b1, `EIS_TX64_COUNT_ADDR, 32'hffff_ffff);
      rdchk(`EIS_TX64_COUNT_ADDR, 32'h2);
      end_sim();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_errors++;
      end_sim();
   end
endmodule
